// [tick_pkg.sv]
// Purpose: shared constants for the periodic wakeup tick counter
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes: divider tables are indexed by the 4-bit divider select code
package tick_pkg;

  // widths
  localparam int COUNT_WIDTH = 8;   // main counter and compare value
  localparam int PRESC_WIDTH = 18;  // holds the largest ratio of 200000
  localparam int DATA_WIDTH = 32;   // wishbone data
  localparam int ADDR_WIDTH = 4;    // wishbone byte address
  localparam int SOURCE_COUNT = 3;  // low power, external, internal

  // register byte offsets
  localparam logic [3:0] ADDR_CONTROL = 4'h0;   // tick_status_control
  localparam logic [3:0] ADDR_COUNT = 4'h4;     // count_value, read only
  localparam logic [3:0] ADDR_MODULO = 4'h8;    // modulo_compare
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;  // mask view of irq enable

  // tick_status_control field positions
  localparam int FLAG_BIT = 7;
  localparam int SRC_HI = 6;
  localparam int SRC_LO = 5;
  localparam int IRQ_EN_BIT = 4;
  localparam int DIV_HI = 3;
  localparam int DIV_LO = 0;

  // reset values
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] MODULO_RESET = 8'h00;
  localparam logic [3:0] DIVIDER_OFF = 4'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // clock source encoding, bit 1 set means internal reference
  typedef enum logic [1:0] {
    SRC_LOW_POWER = 2'h0,
    SRC_EXTERNAL = 2'h1,
    SRC_INTERNAL = 2'h2,
    SRC_INTERNAL_ALT = 2'h3
  } source_type;

  // index of each source pin in the source pin vector
  localparam int PIN_LOW_POWER = 0;
  localparam int PIN_EXTERNAL = 1;
  localparam int PIN_INTERNAL = 2;

  // divide ratios with source bit 0 clear, code 15 down to 0
  localparam logic [15:0][17:0] DIV_TABLE_LOW = {
    18'h003E8, 18'h001F4, 18'h00064, 18'h00010,
    18'h0000A, 18'h00004, 18'h00002, 18'h00001,
    18'h00400, 18'h00200, 18'h00100, 18'h00080,
    18'h00040, 18'h00020, 18'h00008, 18'h00001
  };

  // divide ratios with source bit 0 set, code 15 down to 0
  localparam logic [15:0][17:0] DIV_TABLE_HIGH = {
    18'h30D40, 18'h186A0, 18'h0C350, 18'h04E20,
    18'h02710, 18'h01388, 18'h007D0, 18'h003E8,
    18'h10000, 18'h08000, 18'h04000, 18'h02000,
    18'h01000, 18'h00800, 18'h00400, 18'h00001
  };

  localparam logic [17:0] PRESC_ONE = 18'h00001;

endpackage : tick_pkg

// [clock_source_sync.sv]
// Purpose: bring the three slow source clocks into the system clock
// Assumes: every source runs well below a quarter of the system clock
// Notes: edges are found per source so a source change makes no edge
`timescale 1ns/100ps
module clock_source_sync #(
  parameter int SOURCES = tick_pkg::SOURCE_COUNT
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [SOURCES-1:0] source_pins,
  input wire logic [1:0] source_select,
  output logic source_tick
);

  logic [SOURCES-1:0] meta_ff;   // first stage, read only by sync_ff
  logic [SOURCES-1:0] sync_ff;   // second stage
  logic [SOURCES-1:0] prev_ff;   // last synced level for edge finding
  logic [SOURCES-1:0] rise;      // rising edge per source
  logic tick_ff;
  logic nxt_tick;

  // per-source synchroniser and edge detector
  genvar g;
  generate
    for (g = 0; g < SOURCES; g++) begin : gen_src
      always_ff @(posedge clock) begin
        if (reset) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
          prev_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= source_pins[g];
          sync_ff[g] <= meta_ff[g];
          prev_ff[g] <= sync_ff[g];
        end
      end
      assign rise[g] = sync_ff[g] & ~prev_ff[g];
    end
  endgenerate

  // source mux: 1x internal, 01 external, 00 low power
  always_comb begin
    if (source_select[1]) begin  // [R14]
      nxt_tick = rise[tick_pkg::PIN_INTERNAL];
    end else if (source_select[0]) begin
      nxt_tick = rise[tick_pkg::PIN_EXTERNAL];
    end else begin
      nxt_tick = rise[tick_pkg::PIN_LOW_POWER];
    end
  end

  // registered tick pulse
  always_ff @(posedge clock) begin
    if (reset) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  assign source_tick = tick_ff;

endmodule : clock_source_sync

// [prescaler_divider.sv]
// Purpose: divide source ticks by the selected binary or decimal ratio
// Assumes: clear arrives as a one-cycle pulse from the register logic
// Notes: code zero stops the prescaler and holds it at zero
`timescale 1ns/100ps
module prescaler_divider #(
  parameter int WIDTH = tick_pkg::PRESC_WIDTH
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic source_tick,
  input wire logic [3:0] divider_select,
  input wire logic source_bit0,
  input wire logic clear,
  output logic presc_pulse
);

  logic [WIDTH-1:0] presc_ff;   // ticks seen in this period
  logic [WIDTH-1:0] nxt_presc;
  logic pulse_ff;
  logic nxt_pulse;
  logic [WIDTH-1:0] terminal;   // last count before the output pulse

  // ratio picked jointly by the code and source bit 0
  assign terminal = source_bit0 ?  // [R9]
    WIDTH'(tick_pkg::DIV_TABLE_HIGH[divider_select] - tick_pkg::PRESC_ONE) :
    WIDTH'(tick_pkg::DIV_TABLE_LOW[divider_select] - tick_pkg::PRESC_ONE);

  // next period count and output pulse
  always_comb begin
    nxt_presc = presc_ff;
    nxt_pulse = 1'b0;
    if (clear || divider_select == tick_pkg::DIVIDER_OFF) begin
      nxt_presc = '0;  // [R6]
    end else if (source_tick) begin
      if (presc_ff >= terminal) begin  // [R15]
        nxt_presc = '0;
        nxt_pulse = 1'b1;
      end else begin
        nxt_presc = presc_ff + WIDTH'(tick_pkg::PRESC_ONE);
      end
    end
  end

  // register stage
  always_ff @(posedge clock) begin
    if (reset) begin
      presc_ff <= '0;
      pulse_ff <= 1'b0;
    end else begin
      presc_ff <= nxt_presc;
      pulse_ff <= nxt_pulse;
    end
  end

  assign presc_pulse = pulse_ff;

endmodule : prescaler_divider

// [periodic_wakeup_counter.sv]
// Purpose: 8-bit periodic tick counter with wishbone registers
// Assumes: source clocks are pins far slower than the 50 MHz clock
// Notes: one ack per access, registered a cycle after the request, unmapped reads return zero
//
// How it works
// [R1] 8-bit up counter compared with compare value
// [R2] match wraps count to zero, sets flag
// [R3] compare zero flags every prescaler output edge
// [R4] compare write clears prescaler and count
// [R5] reset: stopped, zeros, prescaler off, low power
// [R6] software starts prescaler with nonzero code
// [R7] changed source select clears prescaler and count
// [R8] changed divider select clears prescaler and count
// [R9] ratio from divider code and source bit0
// [R10] any compare value; count continues after wrap
// [R11] flag sets on step from compare to zero
// [R12] interrupt while flag and enable both set
// [R13] software clears flag by writing one
// [R14] source codes: low power, external, internal
// [R15] binary and decimal divide ratio tables
// [R16] writing zero to flag does nothing
// [R17] count register is read only
// [R18] flag stays set until software clears
// [R19] prescaler off holds count and flag
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
module periodic_wakeup_counter (
  input wire logic clock,
  input wire logic reset,
  input wire logic low_power_osc_clock,
  input wire logic external_ref_clock,
  input wire logic internal_ref_clock,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [3:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  output logic irq
);

  // configuration state
  tick_pkg::source_type source_select_ff;  // clock source
  tick_pkg::source_type nxt_source_select;
  logic [3:0] divider_select_ff;           // prescaler code
  logic [3:0] nxt_divider_select;
  logic tick_irq_enable_ff;                // also the mask register
  logic nxt_tick_irq_enable;
  logic [7:0] modulo_compare_ff;           // wrap value
  logic [7:0] nxt_modulo_compare;

  // counting state
  logic [7:0] count_value_ff;
  logic [7:0] nxt_count_value;
  logic tick_flag_ff;                      // sticky status bit
  logic nxt_tick_flag;
  logic wrap_event;                        // count stepped to zero

  // bus and interrupt outputs
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic irq_ff;
  logic nxt_irq;

  // decoded bus strobes
  logic access;      // new request, not yet answered
  logic wr_low;      // write touching the low byte lane
  logic wr_control;
  logic wr_modulo;
  logic wr_mask;
  logic clear_now;   // restart prescaler and count this cycle

  // submodule links
  logic source_tick;
  logic presc_pulse;

  // bus decode: one access per request, ack pulse ends it
  assign access = wb_cyc & wb_stb & ~ack_ff;
  assign wr_low = access & wb_we & wb_sel[0];
  assign wr_control = wr_low && wb_adr == tick_pkg::ADDR_CONTROL;
  assign wr_modulo = wr_low && wb_adr == tick_pkg::ADDR_MODULO;
  assign wr_mask = wr_low && wb_adr == tick_pkg::ADDR_IRQ_MASK;

  // synchronise the three sources and pick one
  clock_source_sync #(
    .SOURCES(tick_pkg::SOURCE_COUNT)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .source_pins({internal_ref_clock, external_ref_clock,
                  low_power_osc_clock}),
    .source_select(source_select_ff),
    .source_tick(source_tick)
  );

  // binary or decimal divider
  prescaler_divider #(
    .WIDTH(tick_pkg::PRESC_WIDTH)
  ) u_presc (
    .clock(clock),
    .reset(reset),
    .source_tick(source_tick),
    .divider_select(divider_select_ff),
    .source_bit0(source_select_ff[0]),
    .clear(clear_now),
    .presc_pulse(presc_pulse)
  );

  // configuration writes and the restart they cause
  always_comb begin
    nxt_source_select = source_select_ff;
    nxt_divider_select = divider_select_ff;
    nxt_tick_irq_enable = tick_irq_enable_ff;
    nxt_modulo_compare = modulo_compare_ff;
    clear_now = 1'b0;
    if (wr_control) begin
      nxt_source_select = tick_pkg::source_type'(
        wb_dat_w[tick_pkg::SRC_HI:tick_pkg::SRC_LO]);
      nxt_divider_select = wb_dat_w[tick_pkg::DIV_HI:tick_pkg::DIV_LO];
      nxt_tick_irq_enable = wb_dat_w[tick_pkg::IRQ_EN_BIT];
      // only a real change restarts, rewriting the same value is harmless
      if (nxt_source_select != source_select_ff) begin
        clear_now = 1'b1;  // [R7]
      end
      if (nxt_divider_select != divider_select_ff) begin
        clear_now = 1'b1;  // [R8]
      end
    end else if (wr_modulo) begin
      nxt_modulo_compare = wb_dat_w[7:0];  // [R10]
      clear_now = 1'b1;  // [R4]
    end else if (wr_mask) begin
      nxt_tick_irq_enable = wb_dat_w[tick_pkg::FLAG_BIT];
    end
  end

  // count and flag; a write to the count offset is ignored here
  always_comb begin
    nxt_count_value = count_value_ff;  // [R17]
    wrap_event = 1'b0;
    if (clear_now) begin
      nxt_count_value = tick_pkg::COUNT_RESET;
    end else if (presc_pulse) begin  // [R19]
      if (count_value_ff == modulo_compare_ff) begin  // [R1]
        nxt_count_value = tick_pkg::COUNT_RESET;  // [R2]
        wrap_event = 1'b1;  // [R3]
      end else begin
        nxt_count_value = count_value_ff + 8'h01;  // [R10]
      end
    end
    nxt_tick_flag = tick_flag_ff;  // [R18]
    // a one clears, a zero leaves it alone
    if (wr_control && wb_dat_w[tick_pkg::FLAG_BIT]) begin
      nxt_tick_flag = 1'b0;  // [R13] [R16]
    end
    // set beats a same-cycle clear so no tick is lost
    if (wrap_event) begin
      nxt_tick_flag = 1'b1;  // [R11]
    end
    nxt_irq = nxt_tick_flag & nxt_tick_irq_enable;  // [R12]
  end

  // read mux and ack; unmapped offsets read zero and still ack
  always_comb begin
    nxt_ack = access;
    nxt_rdata = tick_pkg::READ_ZERO;
    if (access && !wb_we) begin
      if (wb_adr == tick_pkg::ADDR_CONTROL) begin
        nxt_rdata[7:0] = {tick_flag_ff, source_select_ff,
                          tick_irq_enable_ff, divider_select_ff};
      end else if (wb_adr == tick_pkg::ADDR_COUNT) begin
        nxt_rdata[7:0] = count_value_ff;
      end else if (wb_adr == tick_pkg::ADDR_MODULO) begin
        nxt_rdata[7:0] = modulo_compare_ff;
      end else if (wb_adr == tick_pkg::ADDR_IRQ_MASK) begin
        nxt_rdata[tick_pkg::FLAG_BIT] = tick_irq_enable_ff;
      end
    end
  end

  // register stage for all groups
  always_ff @(posedge clock) begin
    if (reset) begin
      source_select_ff <= tick_pkg::SRC_LOW_POWER;  // [R5]
      divider_select_ff <= tick_pkg::DIVIDER_OFF;
      tick_irq_enable_ff <= 1'b0;
      modulo_compare_ff <= tick_pkg::MODULO_RESET;
      count_value_ff <= tick_pkg::COUNT_RESET;
      tick_flag_ff <= 1'b0;  // [R16]
      ack_ff <= 1'b0;
      rdata_ff <= tick_pkg::READ_ZERO;
      irq_ff <= 1'b0;
    end else begin
      source_select_ff <= nxt_source_select;
      divider_select_ff <= nxt_divider_select;
      tick_irq_enable_ff <= nxt_tick_irq_enable;
      modulo_compare_ff <= nxt_modulo_compare;
      count_value_ff <= nxt_count_value;
      tick_flag_ff <= nxt_tick_flag;
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  assign wb_ack = ack_ff;
  assign wb_dat_r = rdata_ff;
  assign irq = irq_ff;

  // checks on counting, flag, interrupt, reset and bus ack
  a_wrap_to_zero: assert property ( // [R2]
    @(posedge clock) disable iff (reset)
    presc_pulse && !clear_now && count_value_ff == modulo_compare_ff
    |=> count_value_ff == tick_pkg::COUNT_RESET && tick_flag_ff)
    else $error("count did not wrap to zero with flag on match");

  a_count_step: assert property ( // [R10]
    @(posedge clock) disable iff (reset)
    presc_pulse && !clear_now && count_value_ff != modulo_compare_ff
    |=> count_value_ff == $past(count_value_ff) + 8'h01)
    else $error("count did not advance by one");

  a_zero_modulo_flag: assert property ( // [R3]
    @(posedge clock) disable iff (reset)
    presc_pulse && !clear_now && modulo_compare_ff == tick_pkg::MODULO_RESET
    |=> tick_flag_ff && count_value_ff == tick_pkg::COUNT_RESET)
    else $error("zero compare value did not flag");

  a_modulo_clear: assert property ( // [R4]
    @(posedge clock) disable iff (reset)
    wr_modulo |=> count_value_ff == tick_pkg::COUNT_RESET
      && modulo_compare_ff == $past(wb_dat_w[7:0]) && !presc_pulse)
    else $error("compare write did not restart counting");

  a_source_change: assert property ( // [R7]
    @(posedge clock) disable iff (reset)
    wr_control && wb_dat_w[tick_pkg::SRC_HI:tick_pkg::SRC_LO]
      != source_select_ff
    |=> count_value_ff == tick_pkg::COUNT_RESET && !presc_pulse)
    else $error("source change did not clear count");

  a_divider_change: assert property ( // [R8]
    @(posedge clock) disable iff (reset)
    wr_control && wb_dat_w[tick_pkg::DIV_HI:tick_pkg::DIV_LO]
      != divider_select_ff
    |=> count_value_ff == tick_pkg::COUNT_RESET)
    else $error("divider change did not clear count");

  a_irq_follows: assert property ( // [R12]
    @(posedge clock) disable iff (reset)
    irq == (tick_flag_ff && tick_irq_enable_ff))
    else $error("interrupt level disagrees with flag and enable");

  a_flag_sticky: assert property ( // [R18]
    @(posedge clock) disable iff (reset)
    tick_flag_ff && !(wr_control && wb_dat_w[tick_pkg::FLAG_BIT])
    |=> tick_flag_ff)
    else $error("flag dropped without a one written");

  a_flag_clear: assert property ( // [R13]
    @(posedge clock) disable iff (reset)
    wr_control && wb_dat_w[tick_pkg::FLAG_BIT] && !wrap_event
    |=> !tick_flag_ff && !irq)
    else $error("writing one did not clear flag");

  a_hold_when_off: assert property ( // [R19]
    @(posedge clock) disable iff (reset)
    divider_select_ff == tick_pkg::DIVIDER_OFF && !presc_pulse && !clear_now
    |=> $stable(count_value_ff) ##1 !presc_pulse)
    else $error("count moved with prescaler off");

  a_count_read_only: assert property ( // [R17]
    @(posedge clock) disable iff (reset)
    access && wb_we && wb_adr == tick_pkg::ADDR_COUNT && !presc_pulse
    |=> $stable(count_value_ff))
    else $error("write changed the count");

  a_reset_state: assert property ( // [R5]
    @(posedge clock)
    reset |=> count_value_ff == tick_pkg::COUNT_RESET
      && modulo_compare_ff == tick_pkg::MODULO_RESET
      && divider_select_ff == tick_pkg::DIVIDER_OFF
      && source_select_ff == tick_pkg::SRC_LOW_POWER && !tick_flag_ff)
    else $error("reset state wrong");

  a_ack_single: assert property (
    @(posedge clock) disable iff (reset)
    wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack)
    else $error("ack not a single cycle answer");

endmodule : periodic_wakeup_counter

// [tb_periodic_wakeup_counter.sv]
// Purpose: self-checking bench for the periodic wakeup tick counter
// Assumes: 50 MHz clock, wishbone at 0x0 control, 0x4 count, 0x8 compare
// Notes: source pins pulse every 9 clocks, well under clock/4
`timescale 1ns/100ps
module tb_periodic_wakeup_counter;
  logic clock = 1'b0; // system clock
  logic reset = 1'b1; // synchronous, active high
  logic [2:0] src = 3'h0; // low power, external, internal pins
  logic wb_cyc = 1'b0; // bus cycle
  logic wb_stb = 1'b0; // bus strobe
  logic wb_we = 1'b0; // write when high
  logic [3:0] wb_adr = 4'h0; // byte address
  logic [3:0] wb_sel = 4'hF; // byte enables, all lanes on
  logic [31:0] wb_dat_w = 32'h0000_0000; // write data
  logic [31:0] wb_dat_r; // read data
  logic wb_ack; // one-cycle answer
  logic irq; // level interrupt
  int n_mismatch = 0; // failed comparisons
  int num_checks = 0; // all comparisons

  periodic_wakeup_counter periodic_wakeup_counter_inst (
    .clock(clock),
    .reset(reset),
    .low_power_osc_clock(src[0]),
    .external_ref_clock(src[1]),
    .internal_ref_clock(src[2]),
    .wb_cyc(wb_cyc),
    .wb_stb(wb_stb),
    .wb_we(wb_we),
    .wb_adr(wb_adr),
    .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack),
    .irq(irq)
  );

  // free running clock, 20 ns period
  always #10 clock = ~clock;

  // print counts and verdict, then stop
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  // case-equality compare so unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; holds the request until ack is sampled high,
  // a dead slave is caught by the watchdog, not here
  task automatic xfer(input logic we, input logic [3:0] a,
                      input logic [7:0] d, output logic [31:0] q);
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= {24'h00_0000, d};
    do begin
      @(posedge clock);
    end while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : xfer

  // register write, read data ignored
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  // register read compared with expected low byte, upper bits zero
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(q, {24'h00_0000, e});
  endtask : rd

  // irq is registered: let it settle a few edges before looking
  task automatic ck_irq(input logic e);
    repeat (3) @(posedge clock);
    chk({31'h0000_0000, irq}, {31'h0000_0000, e});
  endtask : ck_irq

  // n rising edges on one source pin, 9 clocks apart
  task automatic edges(input int i, input int n);
    repeat (n) begin
      @(posedge clock);
      src[i] <= 1'b1;
      repeat (4) @(posedge clock);
      src[i] <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask : edges

  // end-of-test line
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  // watchdog: the whole run is about 21000 clocks
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    $display("BAD %0t timeout", $time);
    complete_run();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    // reset state: all fields zero, prescaler off
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h00);
    rd(4'hC, 8'h00);
    ck_irq(1'b0);
    edges(0, 3);
    rd(4'h4, 8'h00);
    done("reset");
    // ratio 1 from low power source, compare 2, irq enabled
    wr(4'h0, 8'h18);
    wr(4'h8, 8'h02);
    edges(0, 1);
    rd(4'h4, 8'h01);
    edges(0, 1);
    rd(4'h4, 8'h02);
    rd(4'h0, 8'h18);
    edges(0, 1);
    rd(4'h4, 8'h00);
    rd(4'h0, 8'h98);
    ck_irq(1'b1);
    edges(0, 3);
    rd(4'h0, 8'h98);
    wr(4'h0, 8'h18);
    rd(4'h0, 8'h98);
    edges(0, 1);
    rd(4'h4, 8'h01);
    wr(4'h0, 8'h98);
    rd(4'h0, 8'h18);
    ck_irq(1'b0);
    done("wrap");
    // count is read only; a compare write restarts from zero
    wr(4'h4, 8'hFF);
    rd(4'h4, 8'h01);
    wr(4'h8, 8'h02);
    rd(4'h4, 8'h00);
    // largest compare value wraps after 256 steps
    wr(4'h8, 8'hFF);
    edges(0, 255);
    rd(4'h4, 8'hFF);
    rd(4'h0, 8'h18);
    edges(0, 1);
    rd(4'h4, 8'h00);
    rd(4'h0, 8'h98);
    wr(4'h0, 8'h98);
    done("bounds");
    // compare zero flags on every prescaler pulse
    wr(4'h8, 8'h00);
    edges(0, 1);
    rd(4'h0, 8'h98);
    wr(4'h0, 8'h98);
    edges(0, 1);
    rd(4'h0, 8'h98);
    // enable off: flag set but irq quiet; mask alias turns it on
    wr(4'h0, 8'h88);
    ck_irq(1'b0);
    edges(0, 1);
    rd(4'h0, 8'h88);
    ck_irq(1'b0);
    rd(4'hC, 8'h00);
    wr(4'hC, 8'h80);
    ck_irq(1'b1);
    rd(4'h0, 8'h98);
    wr(4'hC, 8'h00);
    ck_irq(1'b0);
    wr(4'h0, 8'h88);
    done("irq");
    // prescaler off: nothing advances
    wr(4'h0, 8'h00);
    edges(0, 2);
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    done("off");
    // external source, bit0 set, code 8 divides by 1000
    wr(4'h8, 8'h05);
    wr(4'h0, 8'h28);
    edges(1, 999);
    rd(4'h4, 8'h00);
    edges(1, 1);
    rd(4'h4, 8'h01);
    edges(0, 2);
    edges(2, 2);
    rd(4'h4, 8'h01);
    // internal source, bit0 clear, code 9 divides by 2
    wr(4'h0, 8'h49);
    rd(4'h4, 8'h00);
    edges(2, 1);
    rd(4'h4, 8'h00);
    edges(2, 1);
    rd(4'h4, 8'h01);
    edges(1, 2);
    rd(4'h4, 8'h01);
    done("sources");
    // a write without byte lane 0 is dropped, no restart either
    wb_sel <= 4'hE;
    wr(4'h8, 8'h33);
    wb_sel <= 4'hF;
    rd(4'h8, 8'h05);
    rd(4'h4, 8'h01);
    done("lanes");
    // unmapped offset reads zero and ignores writes
    wr(4'h2, 8'h5A);
    rd(4'h2, 8'h00);
    rd(4'h0, 8'h49);
    done("unmapped");
    // source code 11 also picks the internal pin; bit0 set gives 1000
    wr(4'h0, 8'h68);
    rd(4'h0, 8'h68);
    rd(4'h4, 8'h00);
    edges(1, 2);
    edges(2, 999);
    rd(4'h4, 8'h00);
    edges(2, 1);
    rd(4'h4, 8'h01);
    done("alt source");
    // a second reset in mid-run returns every register to idle
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h00);
    ck_irq(1'b0);
    done("reset again");
    complete_run();
  end
endmodule : tb_periodic_wakeup_counter
